// file: hw/vagc_top.sv
// Purpose: Gain control register bank behind a two-wire serial slave
// Assumes: Bus pins are asynchronous; gain path inputs share clk
// Notes:   Subaddress pointer auto-increments on each written byte and each master-acked read byte
//
// How it works
// - Rise speed sits in bits 2:0 at 78h, rise delay at 79h.
// - Fall speed bits 2:0 at 6Fh, delay at 9Eh; speed only on peaks.
// - Range codes 101, 110, 111 pick spans 1.25, 1.5, 1.75 to 1.0.
// - Colour loop starts once chroma amplitude reaches the four-bit threshold.
// - Sync-height disable bit with sync reference turns back-end loop off.
// - Burst disable bit with burst reference turns back-end loop off.
// - Peak disable bit with composite peak reference turns back-end loop off.
// - Firmware version is read-only, fixed, and ignores writes.
`timescale 1ns/100ps
`default_nettype none
module vagc_top import vagc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR   = 7'h5c,
  parameter logic [7:0] FW_VERSION = 8'h5a, // Arbitrary value
  parameter int         AMP_W      = 4
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  input  wire vagc_fe_ref_t     fe_ref,
  input  wire logic             composite_in,
  input  wire logic [AMP_W-1:0] chroma_amp,
  output vagc_ctl_t             ctl
);
  vagc_main_t q_r;
  vagc_main_t q_nxt;
  vagc_regs_t regs;
  logic [7:0] rdata;
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  // Both bus pins pass two flops first
  vagc_sync #(
    .W (2)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({scl_in, sda_in}),
    .q      (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Register storage and read buffer
  vagc_regfile #(
    .FW_VERSION (FW_VERSION)
  ) u_regs (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (q_r.we),
    .waddr  (q_r.waddr),
    .wdata  (q_r.wdata),
    .raddr  (q_r.ptr),
    .rdata  (rdata),
    .regs   (regs)
  );

  // Bus events seen on synchronised levels only
  assign scl_rise  = scl_s & ~q_r.scl_q;
  assign scl_fall  = ~scl_s & q_r.scl_q;
  assign bus_start = scl_s & q_r.scl_q & q_r.sda_q & ~sda_s;
  assign bus_stop  = scl_s & q_r.scl_q & ~q_r.sda_q & sda_s;

  // Span decode; reserved codes fall back to the default span
  function automatic vagc_span_t span_of(input logic [2:0] code);
    case (code)
      RANGE_1P25: span_of = SPAN_1P25;
      RANGE_1P5:  span_of = SPAN_1P5;
      RANGE_1P75: span_of = SPAN_1P75;
      default:    span_of = SPAN_1P5;
    endcase
  endfunction

  // Serial slave sequencing and gain path settings
  always_comb begin
    q_nxt = q_r;
    q_nxt.we = 1'b0;
    q_nxt.scl_q = scl_s;
    q_nxt.sda_q = sda_s;
    case (q_r.st)
      I2C_IDLE: begin
        q_nxt.oe = 1'b0;
      end
      I2C_ADDR, I2C_SUB, I2C_WR: begin
        if (scl_rise) begin
          q_nxt.sh  = {q_r.sh[6:0], sda_s};
          q_nxt.cnt = 3'(q_r.cnt + 3'h1);
          q_nxt.got = (q_r.cnt == 3'h7);
        end else if (scl_fall && q_r.got) begin
          q_nxt.got = 1'b0;
          q_nxt.cnt = 3'h0;
          q_nxt.oe  = 1'b1;
          q_nxt.st  = I2C_ACK;
          if (q_r.st == I2C_ADDR) begin
            // Foreign address: stay off the bus until next start
            if (q_r.sh[7:1] != DEV_ADDR) begin
              q_nxt.oe = 1'b0;
              q_nxt.st = I2C_IDLE;
            end
            q_nxt.after = q_r.sh[0] ? I2C_RD : I2C_SUB;
          end else if (q_r.st == I2C_SUB) begin
            q_nxt.ptr   = q_r.sh;
            q_nxt.after = I2C_WR;
          end else begin
            q_nxt.we    = 1'b1;
            q_nxt.waddr = q_r.ptr;
            q_nxt.wdata = q_r.sh;
            q_nxt.ptr   = 8'(q_r.ptr + 8'h01);
            q_nxt.after = I2C_WR;
          end
        end
      end
      I2C_ACK: begin
        // Ack low held for the whole ninth clock
        if (scl_fall) begin
          q_nxt.oe = 1'b0;
          q_nxt.st = q_r.after;
          if (q_r.after == I2C_RD) begin
            q_nxt.sh  = rdata;
            q_nxt.oe  = ~rdata[7];
            q_nxt.cnt = 3'h0;
          end
        end
      end
      I2C_RD: begin
        if (scl_rise) begin
          q_nxt.cnt = 3'(q_r.cnt + 3'h1);
          q_nxt.got = (q_r.cnt == 3'h7);
        end else if (scl_fall) begin
          if (q_r.got) begin
            q_nxt.got = 1'b0;
            q_nxt.oe  = 1'b0;
            q_nxt.st  = I2C_RD_ACK;
          end else begin
            q_nxt.sh = {q_r.sh[6:0], 1'b0};
            q_nxt.oe = ~q_r.sh[6];
          end
        end
      end
      I2C_RD_ACK: begin
        // Master ack moves the pointer; nack ends the read
        if (scl_rise) begin
          q_nxt.got = ~sda_s;
          if (!sda_s) begin
            q_nxt.ptr = 8'(q_r.ptr + 8'h01);
          end
        end else if (scl_fall) begin
          q_nxt.got = 1'b0;
          q_nxt.cnt = 3'h0;
          if (q_r.got) begin
            q_nxt.st = I2C_RD;
            q_nxt.sh = rdata;
            q_nxt.oe = ~rdata[7];
          end else begin
            q_nxt.st = I2C_IDLE;
          end
        end
      end
      default: begin
        q_nxt.st = I2C_IDLE;
        q_nxt.oe = 1'b0;
      end
    endcase

    // Stop or start overrides any state, even mid-byte
    if (bus_stop) begin
      q_nxt.st = I2C_IDLE;
      q_nxt.oe = 1'b0;
      q_nxt.got = 1'b0;
    end else if (bus_start) begin
      q_nxt.st  = I2C_ADDR;
      q_nxt.oe  = 1'b0;
      q_nxt.cnt = 3'h0;
      q_nxt.got = 1'b0;
    end

    // Rise controls apply to composite inputs
    q_nxt.ctl.rise_speed  = regs.gain_rise_speed[2:0];
    q_nxt.ctl.rise_delay  = regs.gain_rise_delay;
    q_nxt.ctl.rise_active = composite_in;
    // Fall speed only meaningful on peak reference
    q_nxt.ctl.fall_speed  = regs.gain_fall_speed[2:0];
    q_nxt.ctl.fall_delay  = regs.gain_fall_delay;
    q_nxt.ctl.fall_active = (fe_ref == FE_REF_PEAK);
    q_nxt.ctl.gain_span   = span_of(regs.gain_range_select[2:0]);

    // Threshold bypassed while its enable is clear
    if (regs.chroma_gain_threshold[THR_EN_BIT]) begin
      q_nxt.ctl.chroma_gain_loop_on =
        (chroma_amp >= AMP_W'(regs.chroma_gain_threshold[THR_MSB:0]));
    end else begin
      q_nxt.ctl.chroma_gain_loop_on = 1'b1;
    end

    // Conditional back-end disable keyed to front-end reference
    q_nxt.ctl.backend_gain_off =
      ((fe_ref == FE_REF_SYNC)  && regs.backend_gain_disable[SYNC_REF_DIS])  ||
      ((fe_ref == FE_REF_BURST) && regs.backend_gain_disable[BURST_REF_DIS]) ||
      ((fe_ref == FE_REF_PEAK)  && regs.backend_gain_disable[PEAK_REF_DIS]);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= MAIN_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = q_r.oe;
  assign ctl     = q_r.ctl;
endmodule
`default_nettype wire

// file: hw/vagc_pkg.sv
// Purpose: Shared constants and types for the video gain control register bank
// Assumes: 8-bit subaddresses on a two-wire serial register bus
// Notes:   Reset values and field positions live here only
package vagc_pkg;

  // Register subaddresses
  localparam logic [7:0] REG_CHROMA_THR  = 8'h6a;
  localparam logic [7:0] REG_BACKEND_DIS = 8'h6c;
  localparam logic [7:0] REG_FALL_SPEED  = 8'h6f;
  localparam logic [7:0] REG_FW_VERSION  = 8'h70;
  localparam logic [7:0] REG_RISE_SPEED  = 8'h78;
  localparam logic [7:0] REG_RISE_DELAY  = 8'h79;
  localparam logic [7:0] REG_FALL_DELAY  = 8'h9e;
  localparam logic [7:0] REG_RANGE_SEL   = 8'h9f;

  // Reset values
  localparam logic [7:0] RST_CHROMA_THR  = 8'h0a;
  localparam logic [7:0] RST_BACKEND_DIS = 8'h08;
  localparam logic [7:0] RST_FALL_SPEED  = 8'h04;
  localparam logic [7:0] RST_RISE_SPEED  = 8'h05;
  localparam logic [7:0] RST_RISE_DELAY  = 8'h1e;
  localparam logic [7:0] RST_FALL_DELAY  = 8'h00;
  localparam logic [7:0] RST_RANGE_SEL   = 8'h06;

  // Field positions
  localparam int THR_MSB         = 3;
  localparam int THR_EN_BIT      = 4;
  localparam int SYNC_REF_DIS    = 0;
  localparam int BURST_REF_DIS   = 1;
  localparam int PEAK_REF_DIS    = 2;
  localparam int MUST_BE_ONE_BIT = 3;

  // Gain range codes
  localparam logic [2:0] RANGE_1P25 = 3'h5;
  localparam logic [2:0] RANGE_1P5  = 3'h6;
  localparam logic [2:0] RANGE_1P75 = 3'h7;

  typedef enum logic [1:0] {SPAN_1P25, SPAN_1P5, SPAN_1P75} vagc_span_t;
  typedef enum logic [1:0] {FE_REF_SYNC, FE_REF_BURST, FE_REF_PEAK, FE_REF_OTHER} vagc_fe_ref_t;
  typedef enum logic [2:0] {RID_CHROMA, RID_BACKEND, RID_FALL_SPD, RID_FW, RID_RISE_SPD,
                            RID_RISE_DLY, RID_FALL_DLY, RID_RANGE} vagc_rid_t;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_SUB, I2C_WR, I2C_RD,
                            I2C_RD_ACK} vagc_i2c_st_t;

  // Writable register image
  typedef struct packed {
    logic [7:0] chroma_gain_threshold;
    logic [7:0] backend_gain_disable;
    logic [7:0] gain_fall_speed;
    logic [7:0] gain_rise_speed;
    logic [7:0] gain_rise_delay;
    logic [7:0] gain_fall_delay;
    logic [7:0] gain_range_select;
  } vagc_regs_t;

  localparam vagc_regs_t REGS_RST = '{RST_CHROMA_THR, RST_BACKEND_DIS, RST_FALL_SPEED,
                                      RST_RISE_SPEED, RST_RISE_DELAY, RST_FALL_DELAY,
                                      RST_RANGE_SEL};

  // Settings handed to the gain path
  typedef struct packed {
    logic [2:0] rise_speed;
    logic [7:0] rise_delay;
    logic       rise_active;
    logic [2:0] fall_speed;
    logic [7:0] fall_delay;
    logic       fall_active;
    vagc_span_t gain_span;
    logic       chroma_gain_loop_on;
    logic       backend_gain_off;
  } vagc_ctl_t;

  localparam vagc_ctl_t CTL_RST = '{RST_RISE_SPEED[2:0], RST_RISE_DELAY, 1'b0,
                                    RST_FALL_SPEED[2:0], RST_FALL_DELAY, 1'b0,
                                    SPAN_1P5, 1'b1, 1'b0};

  // Serial slave state
  typedef struct packed {
    vagc_i2c_st_t st;
    vagc_i2c_st_t after;
    logic [2:0]   cnt;
    logic [7:0]   sh;
    logic         got;
    logic [7:0]   ptr;
    logic [7:0]   waddr;
    logic [7:0]   wdata;
    logic         we;
    logic         oe;
    logic         scl_q;
    logic         sda_q;
    vagc_ctl_t    ctl;
  } vagc_main_t;

  localparam vagc_main_t MAIN_RST = '{I2C_IDLE, I2C_IDLE, 3'h0, 8'h00, 1'b0, 8'h00,
                                      8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1, CTL_RST};

  // Subaddress to register id; valid flag in the returned bit
  function automatic logic vagc_decode(input logic [7:0] a, output vagc_rid_t id);
    vagc_decode = 1'b1;
    id = RID_FW;
    case (a)
      REG_CHROMA_THR:  id = RID_CHROMA;
      REG_BACKEND_DIS: id = RID_BACKEND;
      REG_FALL_SPEED:  id = RID_FALL_SPD;
      REG_FW_VERSION:  id = RID_FW;
      REG_RISE_SPEED:  id = RID_RISE_SPD;
      REG_RISE_DELAY:  id = RID_RISE_DLY;
      REG_FALL_DELAY:  id = RID_FALL_DLY;
      REG_RANGE_SEL:   id = RID_RANGE;
      default:         vagc_decode = 1'b0;
    endcase
  endfunction

endpackage

// file: hw/vagc_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   Only the second stage leaves this module
`timescale 1ns/100ps
`default_nettype none
module vagc_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [1:0][W-1:0] stage_r;
  logic [1:0][W-1:0] stage_nxt;

  // Stage one feeds stage two only
  always_comb begin
    stage_nxt[0] = d;
    stage_nxt[1] = stage_r[0];
  end

  // Idle bus is high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_r <= '1;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign q = stage_r[1];
endmodule
`default_nettype wire

// file: hw/vagc_regfile.sv
// Purpose: Configuration register storage with registered read data
// Assumes: One write strobe per byte from the serial slave
// Notes:   Unmapped reads return zero; read-only and unmapped writes drop
`timescale 1ns/100ps
`default_nettype none
module vagc_regfile import vagc_pkg::*; #(
  parameter logic [7:0] FW_VERSION = 8'h5a // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata,
  output vagc_regs_t      regs
);
  typedef struct packed {
    vagc_regs_t regs;
    logic [7:0] rdata;
  } vagc_rf_t;

  vagc_rf_t  rf_r;
  vagc_rf_t  rf_nxt;
  vagc_rid_t wid;
  vagc_rid_t rid;
  logic      wok;
  logic      rok;

  // Write, and in the same cycle refresh the read buffer from pre-write contents at the current pointer
  always_comb begin
    rf_nxt = rf_r;
    wok = vagc_decode(waddr, wid);
    rok = vagc_decode(raddr, rid);
    if (we && wok) begin
      case (wid)
        RID_CHROMA:   rf_nxt.regs.chroma_gain_threshold = wdata;
        RID_BACKEND:  rf_nxt.regs.backend_gain_disable  = wdata;
        RID_FALL_SPD: rf_nxt.regs.gain_fall_speed       = wdata;
        RID_RISE_SPD: rf_nxt.regs.gain_rise_speed       = wdata;
        RID_RISE_DLY: rf_nxt.regs.gain_rise_delay       = wdata;
        RID_FALL_DLY: rf_nxt.regs.gain_fall_delay       = wdata;
        RID_RANGE:    rf_nxt.regs.gain_range_select     = wdata;
        default:      rf_nxt.regs = rf_r.regs;
      endcase
    end
    rf_nxt.rdata = 8'h00;
    if (rok) begin
      case (rid)
        RID_CHROMA:   rf_nxt.rdata = rf_r.regs.chroma_gain_threshold;
        RID_BACKEND:  rf_nxt.rdata = rf_r.regs.backend_gain_disable;
        RID_FALL_SPD: rf_nxt.rdata = rf_r.regs.gain_fall_speed;
        RID_FW:       rf_nxt.rdata = FW_VERSION;
        RID_RISE_SPD: rf_nxt.rdata = rf_r.regs.gain_rise_speed;
        RID_RISE_DLY: rf_nxt.rdata = rf_r.regs.gain_rise_delay;
        RID_FALL_DLY: rf_nxt.rdata = rf_r.regs.gain_fall_delay;
        RID_RANGE:    rf_nxt.rdata = rf_r.regs.gain_range_select;
        default:      rf_nxt.rdata = 8'h00;
      endcase
    end
  end

  // Defaults come back on every reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_r <= '{REGS_RST, 8'h00};
    end else begin
      rf_r <= rf_nxt;
    end
  end

  assign rdata = rf_r.rdata;
  assign regs  = rf_r.regs;
endmodule
`default_nettype wire

// file: verif/vagc_top_assertions.sv
// Purpose: Port checks for the gain control register bank
// Assumes: One clock; bus pins seen raw
// Notes:   Register contents are not visible here
`timescale 1ns/100ps
`default_nettype none
module vagc_chk import vagc_pkg::*; #(
  parameter int AMP_W = 4
) (
  input wire logic             clk,
  input wire logic             arst_n,
  input wire logic             scl_in,
  input wire logic             sda_in,
  input wire logic             sda_out,
  input wire logic             sda_oe,
  input wire vagc_fe_ref_t     fe_ref,
  input wire logic             composite_in,
  input wire logic [AMP_W-1:0] chroma_amp,
  input wire vagc_ctl_t        ctl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Bus pin handling; a drive change while SCL is high would fake a START or STOP
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe moved with scl high");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("sda_oe pulse too short");

  // Gain path settings follow their inputs one clock later
  rise_on_a: assert property (composite_in |=> ctl.rise_active)
    else $error("rise_active missing");
  rise_off_a: assert property (!composite_in |=> !ctl.rise_active)
    else $error("rise_active stray");
  fall_on_a: assert property (fe_ref == FE_REF_PEAK |=> ctl.fall_active)
    else $error("fall_active missing");
  fall_off_a: assert property (fe_ref != FE_REF_PEAK |=> !ctl.fall_active)
    else $error("fall_active stray");
  backend_other_a: assert property (fe_ref == FE_REF_OTHER |=> !ctl.backend_gain_off)
    else $error("backend off without reference");
  chroma_max_a: assert property (&chroma_amp |=> ctl.chroma_gain_loop_on)
    else $error("chroma loop off at full amplitude");

  // Main scenarios reached
  cover property ($rose(sda_oe));
  cover property (ctl.backend_gain_off);
  cover property (ctl.gain_span == SPAN_1P75);
endmodule
bind vagc_top vagc_chk #(.AMP_W(AMP_W)) u_chk (.clk, .arst_n, .scl_in, .sda_in, .sda_out,
  .sda_oe, .fe_ref, .composite_in, .chroma_amp, .ctl);
`default_nettype wire

// file: verif/vagc_host.sv
// Purpose: Host master on the two-wire register bus
// Assumes: SCL high and low 8 clocks each; SDA set mid-low
// Notes:   oe high pulls SDA low; one byte per transfer
`timescale 1ns/100ps
`default_nettype none
module vagc_host #(
  parameter logic [6:0] DEV = 7'h5c
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      oe
);
  logic got;
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    oe  = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data held well clear of both SCL edges, sampled mid-high
  task automatic bit_io(input logic b);
    oe <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    got = sda;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic start;
    oe <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    oe <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop;
    oe <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    oe <= 1'b0;
    tick(8);
  endtask
  // Ninth bit released; low there means acknowledge
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i]);
      r[i] = got;
    end
    bit_io(1'b1);
    ack = ~got;
  endtask
  // Register writes only; the host never sends a program image
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [6:0] dv,
                    output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2;
    start();
    xfer({dv, 1'b0}, r, k0);
    xfer(a, r, k1);
    xfer(d, r, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  // Single byte read, ended by a master refusal
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2, n;
    start();
    xfer({DEV, 1'b0}, r, k0);
    xfer(a, r, k1);
    start();
    xfer({DEV, 1'b1}, r, k2);
    xfer(8'hff, d, n);
    stop();
    ok = k0 & k1 & k2 & ~n;
  endtask
endmodule
`default_nettype wire

// file: verif/video_agc_control_regs_tb.sv
// Purpose: Self-checking bench for the gain control register bank
// Assumes: Host model on the bus; gain inputs random between checks
// Notes:   Expected values come from bench tables and functions
`timescale 1ns/100ps
`default_nettype none
module video_agc_control_regs_tb import vagc_pkg::*;;
  localparam logic [6:0] DEV = 7'h5c;
  localparam logic [7:0] FW  = 8'h3c; // Arbitrary value
  logic         clk, arst_n, sda_out, sda_oe, host_oe, scl, composite_in, rnd_on;
  wire logic    sda;
  vagc_fe_ref_t fe_ref;
  logic [3:0]   chroma_amp;
  vagc_ctl_t    ctl;
  logic [31:0]  lfsr;
  int           failures, comparisons;
  logic [7:0]   addr [8] = '{8'h6a, 8'h6c, 8'h6f, 8'h70, 8'h78, 8'h79, 8'h9e, 8'h9f};
  logic [7:0]   rstv [8] = '{8'h0a, 8'h08, 8'h04, FW, 8'h05, 8'h1e, 8'h00, 8'h06};

  // Open-drain wire with pull-up
  assign sda = ~(sda_oe | host_oe);
  vagc_top #(.DEV_ADDR(DEV), .FW_VERSION(FW), .AMP_W(4)) DUT (.clk, .arst_n, .scl_in(scl),
    .sda_in(sda), .sda_out, .sda_oe, .fe_ref, .composite_in, .chroma_amp, .ctl);
  vagc_host #(.DEV(DEV)) host (.clk, .sda, .scl, .oe(host_oe));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic vagc_span_t span_of(input logic [2:0] c);
    return c == 3'h5 ? SPAN_1P25 : (c == 3'h7 ? SPAN_1P75 : SPAN_1P5);
  endfunction
  function automatic logic be_off(input logic [2:0] d, input vagc_fe_ref_t r);
    return r != FE_REF_OTHER && d[r];
  endfunction

  // Random gain inputs; paused so directed checks own the pins
  always @(posedge clk) begin
    if (rnd_on) begin
      lfsr         <= nxt(lfsr);
      fe_ref       <= vagc_fe_ref_t'(lfsr[1:0]);
      composite_in <= lfsr[2];
      chroma_amp   <= lfsr[6:3];
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    rnd_on = 1'b1;
    host.wr(a, d, DEV, ok);
    chk("write ack", 8'h01, {7'h0, ok});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    rnd_on = 1'b1;
    host.rd(a, d, ok);
    chk("read ack", 8'h01, {7'h0, ok});
    chk($sformatf("reg %h", a), e, d);
  endtask
  // Settings settle within three clocks of a pin change
  task automatic drive(input vagc_fe_ref_t r, input logic [3:0] amp);
    rnd_on = 1'b0;
    @(posedge clk);
    fe_ref     <= r;
    chroma_amp <= amp;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    logic [7:0] v;
    logic [7:0] wv [8];
    logic [3:0] thr;
    logic       ok;
    arst_n = 1'b0;
    rnd_on = 1'b1;
    lfsr = 32'h43de;
    fe_ref = FE_REF_OTHER;
    composite_in = 1'b0;
    chroma_amp = 4'h0;
    failures = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (addr[i]) rchk(addr[i], rstv[i]);
    $display("test reset done");
    wreg(8'h03, 8'h01);
    wreg(8'h03, 8'h00);
    rchk(8'h03, 8'h00);
    $display("test startup done");
    // All-ones then random data through the speed and delay registers
    for (int k = 0; k < 2; k++) begin
      foreach (wv[i]) begin
        v = k ? lfsr[15:8] : 8'hff;
        wv[i] = v;
        if (i == 2 || i == 4 || i == 5 || i == 6) begin
          wreg(addr[i], v);
          rchk(addr[i], v);
        end
      end
      drive(FE_REF_OTHER, 4'h0);
      chk("rise speed", {5'h0, wv[4][2:0]}, {5'h0, ctl.rise_speed});
      chk("rise delay", wv[5], ctl.rise_delay);
      chk("fall speed", {5'h0, wv[2][2:0]}, {5'h0, ctl.fall_speed});
      chk("fall delay", wv[6], ctl.fall_delay);
    end
    $display("test speed done");
    wreg(8'h70, ~FW);
    rchk(8'h70, FW);
    $display("test version done");
    for (int c = 5; c < 8; c++) begin
      wreg(8'h9f, 8'(c));
      drive(FE_REF_OTHER, 4'h0);
      chk("span", 8'(span_of(3'(c))), 8'(ctl.gain_span));
    end
    $display("test range done");
    for (int d = 0; d < 8; d++) begin
      wreg(8'h6c, 8'h08 | 8'(d));
      for (int r = 0; r < 4; r++) begin
        drive(vagc_fe_ref_t'(r), 4'h0);
        chk("backend off", {7'h0, be_off(3'(d), vagc_fe_ref_t'(r))},
            {7'h0, ctl.backend_gain_off});
      end
    end
    $display("test backend done");
    thr = lfsr[3:0] | 4'h1;
    wreg(8'h6a, {4'h1, thr});
    drive(FE_REF_OTHER, thr - 4'h1);
    chk("chroma below", 8'h00, {7'h0, ctl.chroma_gain_loop_on});
    drive(FE_REF_OTHER, thr);
    chk("chroma at", 8'h01, {7'h0, ctl.chroma_gain_loop_on});
    wreg(8'h6a, {4'h0, thr});
    drive(FE_REF_OTHER, 4'h0);
    chk("chroma bypass", 8'h01, {7'h0, ctl.chroma_gain_loop_on});
    $display("test chroma done");
    host.wr(8'h78, ~wv[4], DEV ^ 7'h01, ok);
    chk("foreign ack", 8'h00, {7'h0, ok});
    rchk(8'h78, wv[4]);
    $display("test address done");
    arst_n <= 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(8'h9f, 8'h06);
    rchk(8'h6c, 8'h08);
    $display("test rereset done");
    results();
  end
endmodule
`default_nettype wire
